/* File: inc/ldcr_pkg.sv */
// Package for the LED dimming and current register bank.
// Assumes an 8-bit register port driven by a serial bus slave on i_mclk.
package ldcr_pkg;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned CUR1_W        = 12;
    localparam int unsigned CUR1_HI_W     = 4;
    localparam int unsigned BRT_W         = 13;
    localparam int unsigned BRT_HI_W      = 5;
    localparam int unsigned BRT1_W        = 16;
    localparam int unsigned SCALE_W       = 3;
    localparam int unsigned NUM_CL        = 3;

    localparam logic [7:0] OFS_CUR1_HIGH  = 8'h02;
    localparam logic [7:0] OFS_CUR1_LOW   = 8'h03;
    localparam logic [7:0] OFS_BRT2_HIGH  = 8'h04;
    localparam logic [7:0] OFS_BRT2_LOW   = 8'h05;
    localparam logic [7:0] OFS_CUR2       = 8'h06;
    localparam logic [7:0] OFS_BRT3_HIGH  = 8'h07;
    localparam logic [7:0] OFS_BRT3_LOW   = 8'h08;
    localparam logic [7:0] OFS_CUR3       = 8'h09;
    localparam logic [7:0] OFS_BRT4_HIGH  = 8'h0a;
    localparam logic [7:0] OFS_BRT4_LOW   = 8'h0b;
    localparam logic [7:0] OFS_CUR4       = 8'h0c;
    localparam logic [7:0] OFS_CL_STRIDE  = 8'h03;

    localparam logic [7:0] RST_BYTE       = 8'h00;
    localparam logic [4:0] RST_BRT_HI     = 5'h00;
    localparam logic [12:0] RST_BRT       = 13'h0000;
    localparam logic [7:0] RD_UNMAPPED    = 8'h00;

    // Full-scale current in mA for each scale code
    localparam logic [7:0] FS_MA_0        = 8'h19;
    localparam logic [7:0] FS_MA_1        = 8'h1e;
    localparam logic [7:0] FS_MA_2        = 8'h32;
    localparam logic [7:0] FS_MA_3        = 8'h3c;
    localparam logic [7:0] FS_MA_4        = 8'h50;
    localparam logic [7:0] FS_MA_5        = 8'h64;
    localparam logic [7:0] FS_MA_6        = 8'h78;
    localparam logic [7:0] FS_MA_7        = 8'h96;
endpackage : ldcr_pkg

/* File: hw/ldcr_split_reg.sv */
// Split register: staged high byte, low byte commits the combined value.
// Assumes one-cycle write strobes from the register port logic.
module ldcr_split_reg #(
    parameter int unsigned HI_W = 5
) (
    input  wire logic              i_mclk,
    input  wire logic              i_resetn,
    input  wire logic              i_wr_high,
    input  wire logic              i_wr_low,
    input  wire logic [7:0]        i_wdata,
    input  wire logic              i_load,
    input  wire logic [HI_W+7:0]   i_load_value,
    output logic      [HI_W-1:0]   o_high_reg,
    output logic      [7:0]        o_low_reg,
    output logic      [HI_W+7:0]   o_value
);
    logic [HI_W+7:0] value_reg;

    // Staged high byte
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_high_reg <= '0;
        end else if (i_load) begin
            o_high_reg <= i_load_value[HI_W+7:8];
        end else if (i_wr_high) begin
            o_high_reg <= i_wdata[HI_W-1:0];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_low_reg <= ldcr_pkg::RST_BYTE;
        end else if (i_load) begin
            o_low_reg <= i_load_value[7:0];
        end else if (i_wr_low) begin
            o_low_reg <= i_wdata;
        end
    end

    // Commit on low write with latest staged high
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            value_reg <= '0;
        end else if (i_load) begin
            value_reg <= i_load_value;
        end else if (i_wr_low) begin
            value_reg <= {o_high_reg, i_wdata};
        end
    end

    assign o_value = value_reg;
endmodule : ldcr_split_reg

/* File: hw/ldcr_regs.sv */
// LED dimming and current register bank for a four-output driver.
// Assumes a serial bus slave presents single-cycle write/read strobes on i_mclk,
// and start-up logic pulses i_nv_load with stored output-1 current.
//
// Summary of operation
// - High byte first; low write applies value
// - Display mode: output-1 current drives all
// - Output-1 current low byte at 0x03
// - Output-1 current loads from nonvolatile storage
// - Output-2 brightness split at 0x04/0x05
// - Output-2 current at 0x06, reset zero
// - Output-3 brightness split at 0x07/0x08
// - Output-3 current at 0x09, reset zero
// - Output-4 brightness split at 0x0A/0x0B
// - Output-4 current at 0x0C, reset zero
// - Currents relative to selected full scale
// - Scale code picks 25 to 150 mA
// - Output-1 current high nibble at 0x02
// - Cluster uses top 13 brightness bits
module ldcr_regs #(
    parameter int unsigned NUM_CL = ldcr_pkg::NUM_CL
) (
    input  wire logic                          i_mclk,
    input  wire logic                          i_resetn,
    input  wire logic                          i_wr_en,
    input  wire logic                          i_rd_en,
    input  wire logic [ldcr_pkg::ADDR_W-1:0]   i_addr,
    input  wire logic [ldcr_pkg::DATA_W-1:0]   i_wdata,
    input  wire logic                          i_nv_load,
    input  wire logic [ldcr_pkg::CUR1_W-1:0]   i_nv_cur1,
    input  wire logic                          i_display_mode,
    input  wire logic [ldcr_pkg::SCALE_W-1:0]  i_scale_sel,
    input  wire logic [ldcr_pkg::BRT1_W-1:0]   i_out1_brightness,
    output logic      [ldcr_pkg::DATA_W-1:0]   o_rdata,
    output logic                               o_rvalid,
    output logic      [ldcr_pkg::CUR1_W-1:0]   o_out1_current,
    output logic      [ldcr_pkg::CUR1_W-1:0]   o_out2_current,
    output logic      [ldcr_pkg::CUR1_W-1:0]   o_out3_current,
    output logic      [ldcr_pkg::CUR1_W-1:0]   o_out4_current,
    output logic      [ldcr_pkg::BRT1_W-1:0]   o_out1_brt,
    output logic      [ldcr_pkg::BRT1_W-1:0]   o_out2_brt,
    output logic      [ldcr_pkg::BRT1_W-1:0]   o_out3_brt,
    output logic      [ldcr_pkg::BRT1_W-1:0]   o_out4_brt,
    output logic      [7:0]                    o_full_scale_ma
);
    function automatic logic [7:0] brt_high_ofs(input int unsigned idx);
        brt_high_ofs = ldcr_pkg::OFS_BRT2_HIGH + 8'(idx) * ldcr_pkg::OFS_CL_STRIDE;
    endfunction : brt_high_ofs

    function automatic logic [7:0] fs_ma(input logic [2:0] code);
        unique case (code)
            3'h0: fs_ma = ldcr_pkg::FS_MA_0;
            3'h1: fs_ma = ldcr_pkg::FS_MA_1;
            3'h2: fs_ma = ldcr_pkg::FS_MA_2;
            3'h3: fs_ma = ldcr_pkg::FS_MA_3;
            3'h4: fs_ma = ldcr_pkg::FS_MA_4;
            3'h5: fs_ma = ldcr_pkg::FS_MA_5;
            3'h6: fs_ma = ldcr_pkg::FS_MA_6;
            3'h7: fs_ma = ldcr_pkg::FS_MA_7;
        endcase
    endfunction : fs_ma

    logic [3:0]  cur1_high_reg;
    logic [7:0]  cur1_low_reg;
    logic [11:0] cur1_value;
    logic [4:0]  brt_high [NUM_CL];
    logic [7:0]  brt_low  [NUM_CL];
    logic [12:0] brt_val  [NUM_CL];
    logic [7:0]  cur_reg  [NUM_CL];
    logic [7:0]  rdata_next;
    logic [7:0]  full_scale_reg;

    // Output-1 current pair, loaded from storage at start-up
    ldcr_split_reg #(
        .HI_W ( ldcr_pkg::CUR1_HI_W )
    ) u_cur1 (
        .i_mclk       ( i_mclk ),
        .i_resetn     ( i_resetn ),
        .i_wr_high    ( i_wr_en && i_addr == ldcr_pkg::OFS_CUR1_HIGH ),
        .i_wr_low     ( i_wr_en && i_addr == ldcr_pkg::OFS_CUR1_LOW ),
        .i_wdata      ( i_wdata ),
        .i_load       ( i_nv_load ),
        .i_load_value ( i_nv_cur1 ),
        .o_high_reg   ( cur1_high_reg ),
        .o_low_reg    ( cur1_low_reg ),
        .o_value      ( cur1_value )
    );

    generate
        for (genvar g = 0; g < NUM_CL; g++) begin : g_cl
            ldcr_split_reg #(
                .HI_W ( ldcr_pkg::BRT_HI_W )
            ) u_brt (
                .i_mclk       ( i_mclk ),
                .i_resetn     ( i_resetn ),
                .i_wr_high    ( i_wr_en && i_addr == brt_high_ofs(g) ),
                .i_wr_low     ( i_wr_en && i_addr == brt_high_ofs(g) + 8'h01 ),
                .i_wdata      ( i_wdata ),
                .i_load       ( 1'b0 ),
                .i_load_value ( ldcr_pkg::RST_BRT ),
                .o_high_reg   ( brt_high[g] ),
                .o_low_reg    ( brt_low[g] ),
                .o_value      ( brt_val[g] )
            );

            always_ff @(posedge i_mclk) begin
                if (!i_resetn) begin
                    cur_reg[g] <= ldcr_pkg::RST_BYTE;
                end else if (i_wr_en && i_addr == brt_high_ofs(g) + 8'h02) begin
                    cur_reg[g] <= i_wdata;
                end
            end
        end
    endgenerate

    // Read mux
    always_comb begin
        rdata_next = ldcr_pkg::RD_UNMAPPED;
        if (i_addr == ldcr_pkg::OFS_CUR1_HIGH) begin
            rdata_next = {4'h0, cur1_high_reg};
        end else if (i_addr == ldcr_pkg::OFS_CUR1_LOW) begin
            rdata_next = cur1_low_reg;
        end
        for (int i = 0; i < NUM_CL; i++) begin
            if (i_addr == brt_high_ofs(i)) begin
                rdata_next = {3'h0, brt_high[i]};
            end else if (i_addr == brt_high_ofs(i) + 8'h01) begin
                rdata_next = brt_low[i];
            end else if (i_addr == brt_high_ofs(i) + 8'h02) begin
                rdata_next = cur_reg[i];
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_rdata  <= ldcr_pkg::RST_BYTE;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd_en;
            if (i_rd_en) begin
                o_rdata <= rdata_next;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            full_scale_reg <= ldcr_pkg::FS_MA_0;
        end else begin
            full_scale_reg <= fs_ma(i_scale_sel);
        end
    end

    // Effective per-output current and brightness
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_out1_current <= '0;
            o_out2_current <= '0;
            o_out3_current <= '0;
            o_out4_current <= '0;
            o_out1_brt     <= '0;
            o_out2_brt     <= '0;
            o_out3_brt     <= '0;
            o_out4_brt     <= '0;
        end else if (i_display_mode) begin
            o_out1_current <= cur1_value;
            o_out2_current <= cur1_value;
            o_out3_current <= cur1_value;
            o_out4_current <= cur1_value;
            o_out1_brt     <= i_out1_brightness;
            o_out2_brt     <= i_out1_brightness;
            o_out3_brt     <= i_out1_brightness;
            o_out4_brt     <= i_out1_brightness;
        end else begin
            o_out1_current <= cur1_value;
            o_out2_current <= {4'h0, cur_reg[0]};
            o_out3_current <= {4'h0, cur_reg[1]};
            o_out4_current <= {4'h0, cur_reg[2]};
            o_out1_brt     <= {i_out1_brightness[15:3], 3'h0};
            o_out2_brt     <= {brt_val[0], 3'h0};
            o_out3_brt     <= {brt_val[1], 3'h0};
            o_out4_brt     <= {brt_val[2], 3'h0};
        end
    end

    assign o_full_scale_ma = full_scale_reg;
endmodule : ldcr_regs

/* File: test/ldcr_regs_asserts.sv */
// Port-level checks for the LED register bank.
// Assumes a bind onto ldcr_regs with one clock and a synchronous reset.
module ldcr_regs_chk (
    input wire logic        i_mclk, i_resetn, i_wr_en, i_rd_en, i_nv_load, i_display_mode, o_rvalid,
    input wire logic [7:0]  i_addr, i_wdata, o_rdata, o_full_scale_ma,
    input wire logic [2:0]  i_scale_sel,
    input wire logic [11:0] i_nv_cur1, o_out1_current, o_out4_current,
    input wire logic [15:0] i_out1_brightness, o_out1_brt, o_out4_brt
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] FS_MA [8] = '{8'h19, 8'h1e, 8'h32, 8'h3c, 8'h50, 8'h64, 8'h78, 8'h96};
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    sequence s_wr(a);
        i_wr_en && !i_nv_load && i_addr == a;
    endsequence
    sequence s_cl_hold;
        (!i_display_mode && $stable(i_out1_brightness)) [*3];
    endsequence
    sequence s_dp_hold;
        (i_display_mode && $stable(i_out1_brightness)) [*3];
    endsequence
    a_rd_answer: assert property (i_rd_en |=> o_rvalid) else $error("Read not answered");
    a_rd_quiet: assert property (!i_rd_en |=> !o_rvalid) else $error("Spurious read valid");
    a_unmapped_rd: assert property (i_rd_en && (i_addr < 8'h02 || i_addr > 8'h0c) |=> o_rdata == 8'h00)
        else $error("Unmapped read not zero");
    a_resv_bits: assert property (i_rd_en && i_addr == 8'h04 |=> o_rdata[7:5] == 3'h0) else $error("Reserved set");
    a_resv_cur1: assert property (i_rd_en && i_addr == 8'h02 |=> o_rdata[7:4] == 4'h0) else $error("Reserved set");
    a_brt_commit: assert property (s_wr(8'h0b) ##0 s_cl_hold |-> o_out4_brt[10:0] == {$past(i_wdata, 2), 3'h0})
        else $error("Low byte not applied");
    a_cur4_commit: assert property (s_wr(8'h0c) ##0 !i_display_mode [*3] |-> o_out4_current == {4'h0, $past(i_wdata, 2)})
        else $error("Current not applied");
    a_nv_load: assert property (i_nv_load |=> ##1 o_out1_current == $past(i_nv_cur1, 2)) else $error("Load lost");
    a_disp_cur: assert property (i_display_mode [*3] |-> o_out4_current == o_out1_current)
        else $error("Display current differs");
    a_disp_brt: assert property (s_dp_hold |-> o_out4_brt == i_out1_brightness) else $error("Display brt");
    a_cl1_brt: assert property (s_cl_hold |-> o_out1_brt == {i_out1_brightness[15:3], 3'h0}) else $error("Cl brt");
    a_scale_map: assert property (i_resetn |=> o_full_scale_ma == FS_MA[$past(i_scale_sel)])
        else $error("Scale wrong");
endmodule : ldcr_regs_chk

bind ldcr_regs ldcr_regs_chk u_chk (
    .i_mclk, .i_resetn, .i_wr_en, .i_rd_en, .i_nv_load, .i_display_mode, .o_rvalid, .i_addr, .i_wdata,
    .o_rdata, .o_full_scale_ma, .i_scale_sel, .i_nv_cur1, .o_out1_current, .o_out4_current,
    .i_out1_brightness, .o_out1_brt, .o_out4_brt
);

/* File: test/ldcr_host.sv */
// Host model issuing single-strobe register writes and reads.
// Assumes the bank answers a read with o_rvalid one cycle after the strobe.
module ldcr_host (
    input  wire logic       i_mclk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid,
    output logic            o_wr_en,
    output logic            o_rd_en,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr  = 8'h00;
        o_wdata = 8'h00;
    end
    // Callers write a high byte before its low byte
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        o_wr_en <= 1'b1;
        o_addr  <= a;
        o_wdata <= d;
        @(posedge i_mclk);
        o_wr_en <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        o_rd_en <= 1'b1;
        o_addr  <= a;
        @(posedge i_mclk);
        o_rd_en <= 1'b0;
        o_addr  <= ~a;
        #1;
        d = i_rvalid ? i_rdata : 8'hxx;
    endtask : rd
endmodule : ldcr_host

/* File: test/tb_top.sv */
// Self-checking bench for the LED register bank.
// Assumes the host model drives the register port.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_mclk = 1'b0, i_resetn = 1'b0, i_nv_load = 1'b0, i_display_mode = 1'b0;
    logic        i_wr_en, i_rd_en, o_rvalid;
    logic [7:0]  i_addr, i_wdata, o_rdata, o_full_scale_ma, rv;
    logic [2:0]  i_scale_sel = 3'h0;
    logic [11:0] i_nv_cur1 = 12'h000, o_out1_current, o_out2_current, o_out3_current, o_out4_current;
    logic [15:0] i_out1_brightness = 16'h0000, o_out1_brt, o_out2_brt, o_out3_brt, o_out4_brt;
    int          num_errors = 0;
    int          n_compared = 0;
    ldcr_regs u_dut (.i_mclk, .i_resetn, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .i_nv_load, .i_nv_cur1,
        .i_display_mode, .i_scale_sel, .i_out1_brightness, .o_rdata, .o_rvalid, .o_out1_current,
        .o_out2_current, .o_out3_current, .o_out4_current, .o_out1_brt, .o_out2_brt, .o_out3_brt,
        .o_out4_brt, .o_full_scale_ma);
    ldcr_host u_host (.i_mclk, .i_rdata(o_rdata), .i_rvalid(o_rvalid), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
        .o_addr(i_addr), .o_wdata(i_wdata));
    always #12.5 i_mclk = ~i_mclk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask : chk
    task automatic settle;
        repeat (3) @(posedge i_mclk);
        #1;
    endtask : settle
    task automatic finish_test;
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    function automatic logic [15:0] brt(input int k);
        return k == 0 ? o_out2_brt : k == 1 ? o_out3_brt : o_out4_brt;
    endfunction : brt
    function automatic logic [11:0] cur(input int k);
        return k == 0 ? o_out2_current : k == 1 ? o_out3_current : o_out4_current;
    endfunction : cur
    task automatic t_reset;
        for (int a = 0; a < 15; a++) begin
            u_host.rd(8'(a), rv);
            if (a < 2 || a > 3) chk(rv, 16'h0000);
        end
        chk(o_full_scale_ma, 16'h0019);
    endtask : t_reset
    task automatic t_brt;
        for (int k = 0; k < 3; k++) begin
            u_host.wr(8'(4 + 3 * k), 8'hff);
            u_host.wr(8'(5 + 3 * k), 8'h5a);
            settle();
            chk(brt(k), 16'hfad0);
            u_host.rd(8'(4 + 3 * k), rv);
            chk(rv, 16'h001f);
            u_host.wr(8'(4 + 3 * k), 8'h02);
            settle();
            chk(brt(k), 16'hfad0);
            u_host.wr(8'(5 + 3 * k), 8'h11);
            u_host.wr(8'(5 + 3 * k), 8'h22);
            settle();
            chk(brt(k), 16'h1110);
        end
    endtask : t_brt
    task automatic t_cur;
        for (int k = 0; k < 3; k++) begin
            u_host.wr(8'(6 + 3 * k), 8'(8'hc3 + k));
            settle();
            chk(cur(k), 16'(16'h00c3 + k));
            u_host.rd(8'(6 + 3 * k), rv);
            chk(rv, 16'(16'h00c3 + k));
        end
        u_host.wr(8'h02, 8'hf5);
        u_host.wr(8'h03, 8'h9e);
        settle();
        chk(o_out1_current, 16'h059e);
        u_host.rd(8'h02, rv);
        chk(rv, 16'h0005);
        @(posedge i_mclk);
        i_nv_cur1 <= 12'habc;
        i_nv_load <= 1'b1;
        @(posedge i_mclk);
        i_nv_load <= 1'b0;
        settle();
        chk(o_out1_current, 16'h0abc);
        u_host.rd(8'h03, rv);
        chk(rv, 16'h00bc);
    endtask : t_cur
    task automatic t_disp;
        @(posedge i_mclk);
        i_out1_brightness <= 16'hbeef;
        i_display_mode    <= 1'b1;
        settle();
        chk(o_out3_brt, 16'hbeef);
        chk(o_out4_current, 16'h0abc);
        @(posedge i_mclk);
        i_display_mode <= 1'b0;
        settle();
        chk(o_out1_brt, 16'hbee8);
        chk(o_out4_current, 16'h00c5);
    endtask : t_disp
    task automatic t_scale;
        logic [7:0] fs [8] = '{8'h19, 8'h1e, 8'h32, 8'h3c, 8'h50, 8'h64, 8'h78, 8'h96};
        for (int c = 7; c >= 0; c--) begin
            @(posedge i_mclk);
            i_scale_sel <= 3'(c);
            settle();
            chk(16'(o_full_scale_ma), 16'(fs[c]));
        end
    endtask : t_scale
    initial begin
        repeat (10) @(posedge i_mclk);
        i_resetn <= 1'b1;
        t_reset();
        t_brt();
        t_cur();
        t_disp();
        t_scale();
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge i_mclk);
        num_errors++;
        finish_test();
    end
endmodule : tb_top
